// File: inc/sysctl_gpio_pkg.sv
// constants shared by the control register bank and its serial slave port
package sysctl_gpio_pkg;
    localparam logic [7:0] status_low_off   = 8'h00;
    localparam logic [7:0] status_high_off  = 8'h01;
    localparam logic [7:0] sys_high_off     = 8'h06;
    localparam logic [7:0] pin_ctrl_off     = 8'h07;
    localparam logic [7:0] pin_level_off    = 8'h08;
    localparam logic [7:0] sys_high_reset   = 8'hF5;
    localparam logic [7:0] pin_ctrl_reset   = 8'h0F;
    localparam logic [7:0] pin_level_reset  = 8'h00;
    localparam logic [7:0] status_reset     = 8'h00;
    localparam int         conv_on_bit      = 0;
    localparam int         soft_reset_bit   = 1;
    localparam int         auto_inc_bit     = 2;
    localparam int         reserved_lsb     = 3;
    localparam int         sense_lsb        = 4;
    localparam int         pin_count        = 4;
    localparam int         overpower_pins   = 2;
    // arbitrary slave address, not taken from any part
    localparam logic [6:0] slave_addr_reset = 7'h2A;
    localparam logic [2:0] last_bit         = 3'h7;
endpackage : sysctl_gpio_pkg

// File: rtl/serial_slave_port.sv
// byte level two-wire slave: start/stop detect, address match, byte strobes
`timescale 1ns/100ps
module serial_slave_port #(
    parameter logic [6:0] slave_addr = sysctl_gpio_pkg::slave_addr_reset
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe,
    output logic            bus_start,
    output logic            bus_stop,
    output logic            wr_valid,
    output logic [7:0]      wr_byte,
    output logic            rd_take,
    input  wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {st_idle, st_addr, st_addr_ack, st_wr, st_wr_ack, st_rd,
                              st_rd_ack} port_state_type;

    port_state_type state_q;
    logic       scl_q, sda_q, scl_p, sda_p;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [2:0] cnt_q;
    logic       full_q;
    logic       rw_q;
    logic       ack_ok_q;
    logic       oe_q;
    logic       wr_valid_q;
    logic       rd_take_q;
    logic       scl_rise, scl_fall;

    // pins are taken as synchronous; one stage plus a previous copy for edges
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            scl_p <= scl_q;
            sda_p <= sda_q;
        end
    end

    assign scl_rise  = scl_q & ~scl_p;
    assign scl_fall  = ~scl_q & scl_p;
    assign bus_start = scl_q & scl_p & sda_p & ~sda_q;
    assign bus_stop  = scl_q & scl_p & ~sda_p & sda_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= st_idle;
            shift_q    <= 8'h00;
            tx_q       <= 8'h00;
            cnt_q      <= 3'h0;
            full_q     <= 1'b0;
            rw_q       <= 1'b0;
            ack_ok_q   <= 1'b0;
            oe_q       <= 1'b0;
            wr_valid_q <= 1'b0;
            rd_take_q  <= 1'b0;
        end
        else
        begin
            wr_valid_q <= 1'b0;
            rd_take_q  <= 1'b0;
            if (bus_start)
            begin
                state_q <= st_addr;
                cnt_q   <= 3'h0;
                full_q  <= 1'b0;
                oe_q    <= 1'b0;
            end
            else if (bus_stop)
            begin
                state_q <= st_idle;
                oe_q    <= 1'b0;
            end
            else if (scl_rise)
            begin
                unique case (state_q)
                    st_addr, st_wr, st_rd:
                    begin
                        shift_q <= {shift_q[6:0], sda_q};
                        cnt_q   <= cnt_q + 3'h1;
                        full_q  <= (cnt_q == sysctl_gpio_pkg::last_bit);
                    end
                    st_rd_ack:
                        ack_ok_q <= ~sda_q;
                    default:
                        full_q <= 1'b0;
                endcase
            end
            else if (scl_fall)
            begin
                unique case (state_q)
                    st_addr:
                        if (full_q)
                        begin
                            full_q <= 1'b0;
                            if (shift_q[7:1] == slave_addr)
                            begin
                                state_q <= st_addr_ack;
                                rw_q    <= shift_q[0];
                                oe_q    <= 1'b1;
                            end
                            else
                                state_q <= st_idle;
                        end
                    st_addr_ack, st_rd_ack:
                        if (state_q == st_addr_ack && !rw_q)
                        begin
                            state_q <= st_wr;
                            oe_q    <= 1'b0;
                        end
                        else if (state_q == st_addr_ack || ack_ok_q)
                        begin
                            // first data bit must be on the wire before the next rise
                            state_q   <= st_rd;
                            tx_q      <= {rd_data[6:0], 1'b0};
                            oe_q      <= ~rd_data[7];
                            rd_take_q <= 1'b1;
                        end
                        else
                        begin
                            state_q <= st_idle;
                            oe_q    <= 1'b0;
                        end
                    st_wr:
                        if (full_q)
                        begin
                            full_q     <= 1'b0;
                            state_q    <= st_wr_ack;
                            oe_q       <= 1'b1;
                            wr_valid_q <= 1'b1;
                        end
                    st_wr_ack:
                    begin
                        state_q <= st_wr;
                        oe_q    <= 1'b0;
                    end
                    st_rd:
                        if (full_q)
                        begin
                            full_q  <= 1'b0;
                            state_q <= st_rd_ack;
                            oe_q    <= 1'b0;
                        end
                        else
                        begin
                            oe_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    default:
                        oe_q <= 1'b0;
                endcase
            end
        end
    end

    assign sda_oe   = oe_q;
    assign wr_valid = wr_valid_q;
    assign wr_byte  = shift_q;
    assign rd_take  = rd_take_q;
endmodule : serial_slave_port

// File: rtl/sysctl_gpio_regs.sv
// upper system control byte, pin control and pin level registers behind the serial port
// Summary of operation
// - read clears status flags when enabled
// - converter on follows control bit zero
// - protection trip clears converter bit
// - soft reset applies at stop, self clears
// - auto increment advances pointer per byte
// - reserved bits reset to 1111 0
// - release bit one floats, zero pulls low
// - first two pins also pulled by overpower
// - sense bits enable input buffers, reset off
// - level byte latches pin levels when sensed
`timescale 1ns/100ps
module sysctl_gpio_regs #(
    parameter logic [6:0] slave_addr = sysctl_gpio_pkg::slave_addr_reset
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic [3:0] pin_i,
    output logic [3:0]      pin_o,
    output logic [3:0]      pin_oe,
    output logic            buck_converter_on,
    input  wire logic       protection_trip,
    input  wire logic       overpower_short,
    input  wire logic       read_clears_flags,
    input  wire logic [7:0] status_low_set,
    input  wire logic [7:0] status_high_set,
    input  wire logic [7:0] status_low_clear,
    input  wire logic [7:0] status_high_clear,
    output logic [7:0]      status_low_byte,
    output logic [7:0]      status_high_byte
);
    logic       bus_start, bus_stop, wr_valid, rd_take;
    logic [7:0] wr_byte;
    logic [7:0] rd_data;
    logic [7:0] ptr_q;
    logic       ptr_loaded_q;
    logic [7:0] sys_high_q;
    logic [7:0] pin_ctrl_q;
    logic [3:0] level_q;
    logic [7:0] stat_low_q, stat_high_q;
    logic       soft_reset_q;
    logic       data_wr, soft_now;
    logic [7:0] low_rd_clr, high_rd_clr;
    logic [3:0] release_bits, sense_on;

    serial_slave_port #(
        .slave_addr (slave_addr)
    ) port_u (
        .clk       (clk),
        .rstn      (rstn),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_oe    (sda_oe),
        .bus_start (bus_start),
        .bus_stop  (bus_stop),
        .wr_valid  (wr_valid),
        .wr_byte   (wr_byte),
        .rd_take   (rd_take),
        .rd_data   (rd_data)
    );

    assign sda_o    = 1'b0;
    assign data_wr  = wr_valid & ptr_loaded_q;
    // a pending soft reset waits for the end of the transfer so the ack still goes out
    assign soft_now = soft_reset_q & bus_stop;

    // first byte after a write address is the pointer, later bytes are data
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_q        <= 8'h00;
            ptr_loaded_q <= 1'b0;
        end
        else if (soft_now)
        begin
            ptr_q        <= 8'h00;
            ptr_loaded_q <= 1'b0;
        end
        else
        begin
            if (bus_start)
                ptr_loaded_q <= 1'b0;
            if (wr_valid && !ptr_loaded_q)
            begin
                ptr_q        <= wr_byte;
                ptr_loaded_q <= 1'b1;
            end
            else if ((data_wr || rd_take) && sys_high_q[sysctl_gpio_pkg::auto_inc_bit])
                ptr_q <= ptr_q + 8'h01;
        end
    end

    always_comb
    begin
        unique case (ptr_q)
            sysctl_gpio_pkg::status_low_off:  rd_data = stat_low_q;
            sysctl_gpio_pkg::status_high_off: rd_data = stat_high_q;
            sysctl_gpio_pkg::sys_high_off:    rd_data = sys_high_q;
            sysctl_gpio_pkg::pin_ctrl_off:    rd_data = pin_ctrl_q;
            sysctl_gpio_pkg::pin_level_off:   rd_data = {4'h0, level_q};
            default:                          rd_data = 8'h00;
        endcase
    end

    // upper system control byte; a protection trip beats a host write in the same cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sys_high_q   <= sysctl_gpio_pkg::sys_high_reset;
            soft_reset_q <= 1'b0;
        end
        else if (soft_now)
        begin
            sys_high_q   <= sysctl_gpio_pkg::sys_high_reset;
            soft_reset_q <= 1'b0;
        end
        else
        begin
            if (data_wr && ptr_q == sysctl_gpio_pkg::sys_high_off)
            begin
                sys_high_q <= wr_byte;
                soft_reset_q <= wr_byte[sysctl_gpio_pkg::soft_reset_bit];
            end
            if (protection_trip)
                sys_high_q[sysctl_gpio_pkg::conv_on_bit] <= 1'b0;
        end
    end

    assign buck_converter_on = sys_high_q[sysctl_gpio_pkg::conv_on_bit];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            pin_ctrl_q <= sysctl_gpio_pkg::pin_ctrl_reset;
        else if (soft_now)
            pin_ctrl_q <= sysctl_gpio_pkg::pin_ctrl_reset;
        else if (data_wr && ptr_q == sysctl_gpio_pkg::pin_ctrl_off)
            pin_ctrl_q <= wr_byte;
    end

    assign release_bits = pin_ctrl_q[sysctl_gpio_pkg::sense_lsb-1:0];
    assign sense_on     = pin_ctrl_q[7:sysctl_gpio_pkg::sense_lsb];

    genvar gi;
    generate
        for (gi = 0; gi < sysctl_gpio_pkg::pin_count; gi++)
        begin : pin_gen
            // open drain: only ever drives low
            assign pin_o[gi] = 1'b0;
            if (gi < sysctl_gpio_pkg::overpower_pins)
            begin : op_gen
                assign pin_oe[gi] = ~release_bits[gi] | overpower_short;
            end
            else
            begin : plain_gen
                assign pin_oe[gi] = ~release_bits[gi];
            end
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    level_q[gi] <= 1'b0;
                else if (soft_now)
                    level_q[gi] <= 1'b0;
                else
                    level_q[gi] <= sense_on[gi] & pin_i[gi];
            end
        end
    endgenerate

    // read clear drops only the bits actually shifted out; new events still win
    assign low_rd_clr  = (read_clears_flags && rd_take &&
                          ptr_q == sysctl_gpio_pkg::status_low_off) ? rd_data : 8'h00;
    assign high_rd_clr = (read_clears_flags && rd_take &&
                          ptr_q == sysctl_gpio_pkg::status_high_off) ? rd_data : 8'h00;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stat_low_q  <= sysctl_gpio_pkg::status_reset;
            stat_high_q <= sysctl_gpio_pkg::status_reset;
        end
        else if (soft_now)
        begin
            stat_low_q  <= sysctl_gpio_pkg::status_reset;
            stat_high_q <= sysctl_gpio_pkg::status_reset;
        end
        else
        begin
            stat_low_q  <= (stat_low_q & ~(low_rd_clr | status_low_clear))
                           | status_low_set;
            stat_high_q <= (stat_high_q & ~(high_rd_clr | status_high_clear))
                           | status_high_set;
        end
    end

    assign status_low_byte  = stat_low_q;
    assign status_high_byte = stat_high_q;
endmodule : sysctl_gpio_regs

// File: test/sysctl_gpio_regs_sva.sv
// port checker for the control register bank
`timescale 1ns/100ps
module sysctl_gpio_regs_sva (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    input wire logic       buck_converter_on,
    input wire logic       protection_trip,
    input wire logic       overpower_short,
    input wire logic       read_clears_flags,
    input wire logic [7:0] status_low_set,
    input wire logic [7:0] status_low_clear,
    input wire logic [7:0] status_low_byte
);
    logic [7:0] clr_only;
    assign clr_only = status_low_clear & ~status_low_set;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_trip;
        protection_trip ##1 !protection_trip;
    endsequence
    a_drain_only: assert property (pin_o == 4'h0 && sda_o == 1'b0)
        else $error("open drain output driven high");
    a_overpower_pull: assert property (overpower_short |-> pin_oe[1:0] == 2'b11)
        else $error("overpower did not pull pins");
    a_trip_holds_off: assert property (s_trip |-> !buck_converter_on [*3])
        else $error("converter on after trip");
    a_reset_defaults: assert property ($rose(rstn) |->
        buck_converter_on && !sda_oe && pin_oe[3:2] == 2'b00)
        else $error("wrong outputs after reset");
    a_flag_sticks: assert property (status_low_set != 8'h00 |=>
        (status_low_byte & $past(status_low_set)) == $past(status_low_set))
        else $error("status flag not set");
    a_flag_clears: assert property (clr_only != 8'h00 |=>
        (status_low_byte & $past(clr_only)) == 8'h00)
        else $error("status flag not cleared");
    a_flag_holds: assert property ((status_low_set == 8'h00 &&
        status_low_clear == 8'h00 && !read_clears_flags) |=> $stable(status_low_byte))
        else $error("status flags changed without cause");
    a_data_release: assert property (sda_oe |-> ##[1:100] !sda_oe)
        else $error("data line held low too long");
endmodule : sysctl_gpio_regs_sva

bind sysctl_gpio_regs sysctl_gpio_regs_sva chk (.clk, .rstn, .sda_o, .sda_oe, .pin_o,
    .pin_oe, .buck_converter_on, .protection_trip, .overpower_short, .read_clears_flags,
    .status_low_set, .status_low_clear, .status_low_byte);

// File: test/host_master.sv
// two-wire bus master standing in for the host controller
`timescale 1ns/100ps
module host_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    localparam int half = 4;
    logic a;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // data moves one cycle after the clock falls, never beside it
    task automatic bit_put(input logic b);
        tick(1);
        sda_low = ~b;
        tick(half);
        scl = 1'b1;
        tick(half);
        scl = 1'b0;
    endtask : bit_put
    task automatic bit_get(output logic b);
        bit_put(1'b1);
        b = sda;
    endtask : bit_get
    // sda is first released (scl is low there only for a repeated start), then moves after scl has stood high for a full phase; each line changes alone
    task automatic start;
        tick(1);
        sda_low = 1'b0;
        tick(half);
        scl = 1'b1;
        tick(half);
        sda_low = 1'b1;
        tick(half);
        scl = 1'b0;
    endtask : start
    task automatic stop;
        tick(1);
        sda_low = 1'b1;
        tick(half);
        scl = 1'b1;
        tick(half);
        sda_low = 1'b0;
        tick(half);
    endtask : stop
    task automatic put(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) bit_put(v[i]);
        bit_get(a);
    endtask : put
    task automatic head(input logic [7:0] ptr);
        start();
        put({sysctl_gpio_pkg::slave_addr_reset, 1'b0});
        put(ptr);
    endtask : head
    task automatic write_regs(input logic [7:0] ptr, input int n, input logic [7:0] d [4]);
        head(ptr);
        for (int i = 0; i < n; i++) put(d[i]);
        stop();
    endtask : write_regs
    // all n bytes are fetched inside one transaction
    task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] d [4]);
        head(ptr);
        start();
        put({sysctl_gpio_pkg::slave_addr_reset, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            for (int j = 7; j >= 0; j--) bit_get(d[i][j]);
            bit_put(i == n - 1);
        end
        stop();
    endtask : read_regs
endmodule : host_master

// File: test/sysctl_gpio_regs_test.sv
// self-checking bench for the control register bank
`timescale 1ns/100ps
module sysctl_gpio_regs_test;
    logic clk, rstn, scl_i, sda_i, sda_o, sda_oe, sda_low, buck_converter_on;
    logic protection_trip, overpower_short, read_clears_flags;
    logic [3:0] pin_i, pin_o, pin_oe, pin_drv;
    logic [7:0] status_low_set, status_high_set, status_low_clear, status_high_clear;
    logic [7:0] status_low_byte, status_high_byte, v;
    logic [7:0] wd [4];
    logic [7:0] rd [4];
    logic [31:0] seed;
    int fail_count, compares;
    // pull-up on the data line; released pins read pin_drv
    assign sda_i = ~(sda_oe | sda_low);
    assign pin_i = pin_drv & ~pin_oe;
    sysctl_gpio_regs dut (.clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe, .pin_i, .pin_o,
        .pin_oe, .buck_converter_on, .protection_trip, .overpower_short, .read_clears_flags,
        .status_low_set, .status_high_set, .status_low_clear, .status_high_clear,
        .status_low_byte, .status_high_byte);
    host_master host (.clk, .sda(sda_i), .scl(scl_i), .sda_low);
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs
    function automatic logic [3:0] exp_oe(input logic [3:0] r, input logic o);
        return {~r[3:2], ~r[1:0] | {2{o}}};
    endfunction : exp_oe
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic pulse_status(input logic [7:0] lo, input logic [7:0] hi);
        status_low_set = lo;
        status_high_set = hi;
        @(negedge clk);
        status_low_set = 8'h00;
        status_high_set = 8'h00;
    endtask : pulse_status
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial
    begin
        seed = 32'hD8412BD0;
        {rstn, protection_trip, overpower_short, read_clears_flags, pin_drv} = '0;
        {status_low_set, status_high_set, status_low_clear, status_high_clear} = '0;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        host.read_regs(sysctl_gpio_pkg::sys_high_off, 3, rd);
        check("sys_high", rd[0], sysctl_gpio_pkg::sys_high_reset);
        check("pin_ctrl", rd[1], sysctl_gpio_pkg::pin_ctrl_reset);
        check("pin_level", rd[2], sysctl_gpio_pkg::pin_level_reset);
        check("buck_on", {7'h00, buck_converter_on}, 8'h01);
        $display("test defaults done");
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 8'h0F : xs();
            pin_drv = (i == 0) ? 4'hF : seed[11:8];
            overpower_short = (i == 0) ? 1'b0 : seed[12];
            wd[0] = v;
            host.write_regs(sysctl_gpio_pkg::pin_ctrl_off, 1, wd);
            check("pin_oe", {4'h0, pin_oe}, {4'h0, exp_oe(v[3:0], overpower_short)});
            host.read_regs(sysctl_gpio_pkg::pin_ctrl_off, 2, rd);
            check("pin_ctrl", rd[0], v);
            check("pin_level", rd[1],
                {4'h0, v[7:4] & pin_drv & ~exp_oe(v[3:0], overpower_short)});
        end
        overpower_short = 1'b0;
        $display("test pins done");
        for (int i = 0; i < 2; i++)
        begin
            wd[0] = {7'h02, i[0]};
            host.write_regs(sysctl_gpio_pkg::sys_high_off, 1, wd);
            check("buck_on", {7'h00, buck_converter_on}, {7'h00, i[0]});
        end
        protection_trip = 1'b1;
        @(negedge clk);
        protection_trip = 1'b0;
        @(negedge clk);
        check("buck_trip", {7'h00, buck_converter_on}, 8'h00);
        $display("test converter done");
        wd = '{8'h01, 8'h5A, 8'hAF, 8'h00};
        host.write_regs(sysctl_gpio_pkg::sys_high_off, 1, wd);
        wd = '{8'h5A, 8'hAF, 8'h00, 8'h00};
        host.write_regs(sysctl_gpio_pkg::pin_ctrl_off, 2, wd);
        host.read_regs(sysctl_gpio_pkg::pin_ctrl_off, 2, rd);
        check("fixed_ptr0", rd[0], 8'hAF);
        check("fixed_ptr1", rd[1], 8'hAF);
        wd[0] = 8'h03;
        host.write_regs(sysctl_gpio_pkg::sys_high_off, 1, wd);
        host.read_regs(sysctl_gpio_pkg::sys_high_off, 3, rd);
        check("swr_sys", rd[0], sysctl_gpio_pkg::sys_high_reset);
        check("swr_pin", rd[1], sysctl_gpio_pkg::pin_ctrl_reset);
        $display("test pointer and soft reset done");
        for (int i = 1; i >= 0; i--)
        begin
            read_clears_flags = i[0];
            pulse_status(8'hA5, 8'h3C);
            host.read_regs(sysctl_gpio_pkg::status_low_off, 2, rd);
            check("stat_lo", rd[0], 8'hA5);
            check("stat_hi", rd[1], 8'h3C);
            check("stat_lo_after", status_low_byte, i[0] ? 8'h00 : 8'hA5);
            check("stat_hi_after", status_high_byte, i[0] ? 8'h00 : 8'h3C);
        end
        status_low_clear = 8'hFF;
        status_high_clear = 8'hFF;
        @(negedge clk);
        {status_low_clear, status_high_clear} = '0;
        @(negedge clk);
        check("stat_cleared", status_low_byte | status_high_byte, 8'h00);
        $display("test status done");
        end_sim();
    end
endmodule : sysctl_gpio_regs_test
